// file: bcc_consts.vh
// Constants for the buck converter control sequencer.
`ifndef BCC_CONSTS_VH
`define BCC_CONSTS_VH
`define BCC_CLK_HZ          25000000
`define BCC_SS_TIME_US      8000
`define BCC_SS_CYCLES       ((`BCC_SS_TIME_US * 25) / 1)
`define BCC_HICCUP_TIME_US  16000
`define BCC_HICCUP_CYCLES   ((`BCC_HICCUP_TIME_US * 25) / 1)
`define BCC_DROP_TIME_NS    10000
`define BCC_DROP_CYCLES     ((`BCC_DROP_TIME_NS * 25) / 1000)
`define BCC_LSFORCE_TIME_NS 150
`define BCC_LSFORCE_CYCLES  (((`BCC_LSFORCE_TIME_NS * 25) + 999) / 1000)
`define BCC_VOUT_TARGET_MV  5200
`define BCC_VOUT_GOOD_MV    2500
`define BCC_DUTY_MAX_PCT    98
`define BCC_FSW_MIN_KHZ     400
`define BCC_FSW_MAX_KHZ     2200
`define BCC_SPREAD_PERMIL   30
`define BCC_REF_W           16
`define BCC_FSET_W          12
`endif

// file: bcc_timer.v
// Down-counting timer that pulses done when a loaded count expires.
`default_nettype none
module bcc_timer #(
	parameter W = 24
) (
	input  wire         clk_sys,
	input  wire         reset,
	input  wire         start,
	input  wire [W-1:0] loadVal,
	input  wire         clear,
	output reg          busy,
	output reg          done
);
	reg [W-1:0] cnt_q;

	// Start reloads; clear aborts silently so a dead timer never fires late.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cnt_q <= {W{1'b0}};
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (clear) begin
				busy <= 1'b0;
			end else if (start) begin
				cnt_q <= loadVal;
				busy  <= 1'b1;
			end else if (busy) begin
				if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // bcc_timer
`default_nettype wire

// file: bcc_pwm.v
// Switching-cycle generator with duty limit, spread spectrum and dropout refresh.
`default_nettype none
module bcc_pwm #(
	parameter FW         = 12,
	parameter SPREAD     = 1,
	parameter DROP_CYC   = 250,
	parameter LSF_CYC    = 4,
	parameter DUTY_PCT   = 98
) (
	input  wire          clk_sys,
	input  wire          reset,
	input  wire          run,
	input  wire [FW-1:0] periodSet,
	input  wire [FW-1:0] dutyReq,
	input  wire          ilimTrip,
	input  wire          ilimValley,
	output reg           hsOn,
	output reg           lsOn,
	output reg           cycleStart
);
	reg [FW-1:0] phase_q;
	reg [FW-1:0] period;
	reg [FW-1:0] dutyMax;
	reg [FW-1:0] onTime;
	reg [6:0]    sweep_q;
	reg          sweepUp_q;
	reg [15:0]   hsRun_q;
	reg [7:0]    lsf_q;
	reg          ilimHold_q;
	reg [FW+6:0] prod;
	reg [FW+6:0] dev;
	// Sized copy of the cap so the duty product keeps its own width.
	localparam [6:0] DUTY_W = DUTY_PCT[6:0];

	// Period is swept +-3 percent in a triangle when spread is built in.
	always @* begin
		dev    = ({7'h00, periodSet} * {{(FW){1'b0}}, 7'h03}) / {{(FW){1'b0}}, 7'h64};
		period = periodSet;
		if (SPREAD != 0) begin
			period = periodSet - dev[FW-1:0] +
				((dev[FW-1:0] * {{(FW-7){1'b0}}, sweep_q}) >> 5);
		end
		prod    = ({7'h00, period} * DUTY_W) / 7'h64;
		dutyMax = prod[FW-1:0];
		onTime  = (dutyReq > dutyMax) ? dutyMax : dutyReq;
	end

	// Phase counter, duty compare, current limit hold and dropout timer.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			phase_q    <= {FW{1'b0}};
			sweep_q    <= 7'h00;
			sweepUp_q  <= 1'b1;
			hsRun_q    <= 16'h0000;
			lsf_q      <= 8'h00;
			ilimHold_q <= 1'b0;
			hsOn       <= 1'b0;
			lsOn       <= 1'b0;
			cycleStart <= 1'b0;
		end else if (!run) begin
			phase_q    <= {FW{1'b0}};
			hsRun_q    <= 16'h0000;
			lsf_q      <= 8'h00;
			ilimHold_q <= 1'b0;
			hsOn       <= 1'b0;
			lsOn       <= 1'b0;
			cycleStart <= 1'b0;
		end else begin
			cycleStart <= (phase_q >= period - {{(FW-1){1'b0}}, 1'b1});
			if (phase_q >= period - {{(FW-1){1'b0}}, 1'b1}) begin
				phase_q <= {FW{1'b0}};
				// Turn at the ends so the sweep never wraps past zero or the top.
				if (sweepUp_q) begin
					if (sweep_q == 7'h40) begin
						sweepUp_q <= 1'b0;
						sweep_q   <= sweep_q - 7'h01;
					end else begin
						sweep_q <= sweep_q + 7'h01;
					end
				end else begin
					if (sweep_q == 7'h00) begin
						sweepUp_q <= 1'b1;
						sweep_q   <= sweep_q + 7'h01;
					end else begin
						sweep_q <= sweep_q - 7'h01;
					end
				end
			end else begin
				phase_q <= phase_q + {{(FW-1){1'b0}}, 1'b1};
			end
			// Held off until below valley; the high side may then turn on again in the same cycle while phase is below onTime.
			if (ilimTrip) begin
				ilimHold_q <= 1'b1;
			end else if (ilimValley) begin
				ilimHold_q <= 1'b0;
			end
			if (lsf_q != 8'h00) begin
				lsf_q <= lsf_q - 8'h01;
				hsOn  <= 1'b0;
				lsOn  <= 1'b1;
			end else if (hsRun_q >= DROP_CYC[15:0] - 16'h0001) begin
				hsRun_q <= 16'h0000;
				lsf_q   <= LSF_CYC[7:0] - 8'h01;
				hsOn    <= 1'b0;
				lsOn    <= 1'b1;
			end else begin
				hsOn <= (phase_q < onTime) && !ilimTrip && !ilimHold_q;
				// Forced mode: low side conducts every off period at any load.
				lsOn <= !((phase_q < onTime) && !ilimTrip && !ilimHold_q);
				// Riding the duty cap means the high side is on all the loop allows,
				// so that run counts as continuous on-time for the dropout refresh.
				if (dutyReq >= dutyMax && !ilimTrip && !ilimHold_q) begin
					hsRun_q <= hsRun_q + 16'h0001;
				end else begin
					hsRun_q <= 16'h0000;
				end
			end
		end
	end
endmodule // bcc_pwm
`default_nettype wire

// file: bcc_sequencer.v
// Top-level sequencer: enable, bias lockout, soft-start, hiccup, thermal, port guards.
//
// Notes on behaviour
// - Fixed 5.2V target, always forced PWM.
// - Reference ramps zero to target in 8ms.
// - Frequency set by resistor, 400kHz to 2.2MHz.
// - Spread option sweeps frequency about 3 percent.
// - Enable starts regulator; soft-start after 3V bias.
// - Enable low shuts regulator and gate drivers.
// - Duty cycle capped near 98 percent.
// - Dropout: force low side 150ns every 10us.
// - Over 10A: high side off until valley.
// - Output above 2.5V: retry next cycle; the high side comes back in the same cycle once below valley.
// - Limit below 2.5V: 16ms reset, soft-start.
// - Soft-start end below 2.5V repeats hiccup.
// - Over 165C thermal flag disables converter.
// - Re-enable after cooling 15C below trip.
// - Each charger channel has its own protection.
`include "bcc_consts.vh"
`default_nettype none
module bcc_sequencer #(
	parameter SPREAD     = 1,
	parameter SS_CYC     = `BCC_SS_CYCLES,
	parameter HICCUP_CYC = `BCC_HICCUP_CYCLES
) (
	input  wire                   clk_sys,
	input  wire                   reset,
	input  wire                   highVoltageEnable,
	input  wire                   biasAboveLockout,
	input  wire                   outAboveGood,
	input  wire                   ilimTrip,
	input  wire                   ilimValley,
	input  wire                   thermalHot,
	input  wire                   thermalCool,
	input  wire [`BCC_FSET_W-1:0] frequencySetInput,
	input  wire [`BCC_FSET_W-1:0] dutyRequest,
	input  wire                   portOneFault,
	input  wire                   portTwoFault,
	output reg                    biasRegulatorOn,
	output wire                   highSideOn,
	output wire                   lowSideOn,
	output reg  [`BCC_REF_W-1:0]  outputReference,
	output reg                    converterRunning,
	output reg                    inHiccup,
	output reg                    thermalShutdown,
	output reg                    portOneBusOutput,
	output reg                    portTwoBusOutput
);
	localparam ST_OFF    = 3'h0;
	localparam ST_BIAS   = 3'h1;
	localparam ST_SOFT   = 3'h2;
	localparam ST_RUN    = 3'h3;
	localparam ST_HICCUP = 3'h4;
	localparam ST_THERM  = 3'h5;
	// Work the limits out at full width first, then keep only the bits that
	// the reference and the period really carry, so no width is lost silently.
	// The period limits are whole clock cycles, rounded towards the legal span.
	localparam [31:0] REF_FULL_W = `BCC_VOUT_TARGET_MV;
	localparam [31:0] PER_MIN_W  = `BCC_CLK_HZ / (`BCC_FSW_MAX_KHZ * 1000) + 1;
	localparam [31:0] PER_MAX_W  = `BCC_CLK_HZ / (`BCC_FSW_MIN_KHZ * 1000);
	localparam [`BCC_REF_W-1:0] REF_FULL = REF_FULL_W[`BCC_REF_W-1:0];
	localparam [31:0] SS_STEP_CYC = SS_CYC / `BCC_VOUT_TARGET_MV;
	localparam [`BCC_FSET_W-1:0] PER_MIN = PER_MIN_W[`BCC_FSET_W-1:0];
	localparam [`BCC_FSET_W-1:0] PER_MAX = PER_MAX_W[`BCC_FSET_W-1:0];

	reg [2:0]  state_q;
	reg [2:0]  state_d;
	reg [31:0] stepCnt_q;
	reg        ssStart;
	reg        hicStart;
	reg        thermLatch_q;
	reg [`BCC_FSET_W-1:0] periodSel;
	wire       ssBusy;
	wire       ssDone;
	wire       hicBusy;
	wire       hicDone;
	wire       pwmRun;
	wire       cycleStart;
	wire [1:0] portFault;
	wire [1:0] portOn;

	// Clamp the resistor-derived period into the legal frequency span.
	always @* begin
		periodSel = frequencySetInput;
		if (frequencySetInput < PER_MIN) begin
			periodSel = PER_MIN;
		end else if (frequencySetInput > PER_MAX) begin
			periodSel = PER_MAX;
		end
	end

	// Next-state logic; enable low overrides everything.
	always @* begin
		state_d  = state_q;
		ssStart  = 1'b0;
		hicStart = 1'b0;
		case (state_q)
			ST_OFF: begin
				if (highVoltageEnable) begin
					state_d = ST_BIAS;
				end
			end
			ST_BIAS: begin
				if (thermLatch_q) begin
					state_d = ST_THERM;
				end else if (biasAboveLockout) begin
					state_d = ST_SOFT;
					ssStart = 1'b1;
				end
			end
			ST_SOFT: begin
				if (thermLatch_q) begin
					state_d = ST_THERM;
				end else if (ilimTrip && !outAboveGood) begin
					state_d  = ST_HICCUP;
					hicStart = 1'b1;
				end else if (ssDone) begin
					if (outAboveGood) begin
						state_d = ST_RUN;
					end else begin
						state_d  = ST_HICCUP;
						hicStart = 1'b1;
					end
				end
			end
			ST_RUN: begin
				if (thermLatch_q) begin
					state_d = ST_THERM;
				end else if (ilimTrip && !outAboveGood) begin
					state_d  = ST_HICCUP;
					hicStart = 1'b1;
				end
			end
			ST_HICCUP: begin
				if (thermLatch_q) begin
					state_d = ST_THERM;
				end else if (hicDone) begin
					state_d = ST_SOFT;
					ssStart = 1'b1;
				end
			end
			ST_THERM: begin
				if (!thermLatch_q) begin
					state_d = ST_SOFT;
					ssStart = 1'b1;
				end
			end
			default: begin
				state_d = ST_OFF;
			end
		endcase
		if (!highVoltageEnable) begin
			state_d  = ST_OFF;
			ssStart  = 1'b0;
			hicStart = 1'b0;
		end
	end

	// Thermal latch with hysteresis: set hot, cleared only by the cool flag.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			thermLatch_q <= 1'b0;
		end else if (thermalHot) begin
			thermLatch_q <= 1'b1;
		end else if (thermalCool) begin
			thermLatch_q <= 1'b0;
		end
	end

	// State register, reference ramp and status outputs.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_q          <= ST_OFF;
			stepCnt_q        <= 32'h0000_0000;
			outputReference  <= {`BCC_REF_W{1'b0}};
			biasRegulatorOn  <= 1'b0;
			converterRunning <= 1'b0;
			inHiccup         <= 1'b0;
			thermalShutdown  <= 1'b0;
		end else begin
			state_q          <= state_d;
			biasRegulatorOn  <= (state_d != ST_OFF);
			converterRunning <= (state_d == ST_RUN);
			inHiccup         <= (state_d == ST_HICCUP);
			thermalShutdown  <= (state_d == ST_THERM);
			if (state_d != ST_SOFT && state_d != ST_RUN) begin
				outputReference <= {`BCC_REF_W{1'b0}};
				stepCnt_q       <= 32'h0000_0000;
			end else if (state_d == ST_RUN) begin
				outputReference <= REF_FULL;
			end else if (ssStart) begin
				outputReference <= {`BCC_REF_W{1'b0}};
				stepCnt_q       <= 32'h0000_0000;
			end else if (outputReference < REF_FULL) begin
				// A millivolt per step makes the ramp length track the soft-start time.
				if (stepCnt_q + 32'h0000_0001 >= SS_STEP_CYC) begin
					stepCnt_q       <= 32'h0000_0000;
					outputReference <= outputReference + 16'h0001;
				end else begin
					stepCnt_q <= stepCnt_q + 32'h0000_0001;
				end
			end
		end
	end

	// Soft-start length timer.
	bcc_timer #(.W(32)) ssTimer (
		.clk_sys (clk_sys),
		.reset   (reset),
		.start   (ssStart),
		.loadVal (SS_CYC),
		.clear   (state_q != ST_SOFT && !ssStart),
		.busy    (ssBusy),
		.done    (ssDone)
	);

	// Hiccup reset hold timer.
	bcc_timer #(.W(32)) hicTimer (
		.clk_sys (clk_sys),
		.reset   (reset),
		.start   (hicStart),
		.loadVal (HICCUP_CYC),
		.clear   (state_q != ST_HICCUP && !hicStart),
		.busy    (hicBusy),
		.done    (hicDone)
	);

	// Gate drivers only switch while soft-starting or running.
	assign pwmRun = (state_q == ST_SOFT) || (state_q == ST_RUN);

	bcc_pwm #(
		.FW       (`BCC_FSET_W),
		.SPREAD   (SPREAD),
		.DROP_CYC (`BCC_DROP_CYCLES),
		.LSF_CYC  (`BCC_LSFORCE_CYCLES),
		.DUTY_PCT (`BCC_DUTY_MAX_PCT)
	) pwm (
		.clk_sys    (clk_sys),
		.reset      (reset),
		.run        (pwmRun),
		.periodSet  (periodSel),
		.dutyReq    (dutyRequest),
		.ilimTrip   (ilimTrip),
		.ilimValley (ilimValley),
		.hsOn       (highSideOn),
		.lsOn       (lowSideOn),
		.cycleStart (cycleStart)
	);

	// Per-port bus switches; one channel faulting leaves the other alone.
	assign portFault = {portTwoFault, portOneFault};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : portGuard
			assign portOn[gi] = (state_q == ST_RUN) && !portFault[gi];
		end
	endgenerate

	// Register the port switches so they only ever change on a clock edge.
	// They follow the run state one cycle late, which the load never notices.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			portOneBusOutput <= 1'b0;
			portTwoBusOutput <= 1'b0;
		end else begin
			portOneBusOutput <= portOn[0];
			portTwoBusOutput <= portOn[1];
		end
	end
endmodule // bcc_sequencer
`default_nettype wire

// file: bcc_sequencer_chk.sv
// Concurrent checks on the converter sequencer ports.
`default_nettype none
module bcc_sequencer_chk #(
	parameter SS_CYC     = 5200,
	parameter HICCUP_CYC = 100
) (
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic        highVoltageEnable,
	input wire logic        biasAboveLockout,
	input wire logic        outAboveGood,
	input wire logic        ilimTrip,
	input wire logic        thermalHot,
	input wire logic        thermalCool,
	input wire logic [11:0] frequencySetInput,
	input wire logic        portOneFault,
	input wire logic        biasRegulatorOn,
	input wire logic        highSideOn,
	input wire logic        lowSideOn,
	input wire logic [15:0] outputReference,
	input wire logic        converterRunning,
	input wire logic        inHiccup,
	input wire logic        thermalShutdown,
	input wire logic        portOneBusOutput
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] hsCnt_q;
	logic [19:0] ssCnt_q;
	logic [19:0] hicCnt_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Run lengths; wide counts so a stuck state cannot wrap back into range.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			hsCnt_q <= 12'h0;
			ssCnt_q <= 20'h0;
			hicCnt_q <= 20'h0;
		end else begin
			hsCnt_q <= highSideOn ? hsCnt_q + 12'h1 : 12'h0;
			ssCnt_q <= (outputReference != 16'h0 && !converterRunning) ? ssCnt_q + 20'h1 : 20'h0;
			hicCnt_q <= inHiccup ? hicCnt_q + 20'h1 : 20'h0;
		end
	end
	sequence s_trip;
		ilimTrip ##1 ilimTrip;
	endsequence
	property p_off;
		!highVoltageEnable |=> !biasRegulatorOn && !converterRunning && outputReference == 16'h0;
	endproperty
	a_off: assert property (p_off) else $error("outputs live after enable low");
	property p_gate; !highVoltageEnable [*2] |=> !highSideOn && !lowSideOn; endproperty
	a_gate: assert property (p_gate) else $error("gate on in shutdown");
	property p_lock; !biasAboveLockout |=> outputReference == 16'h0; endproperty
	a_lock: assert property (p_lock) else $error("ramp before bias ok");
	property p_top; converterRunning |-> outputReference == 16'h1450; endproperty
	a_top: assert property (p_top) else $error("running off target");
	property p_ss;
		$rose(converterRunning) |-> ssCnt_q >= SS_CYC - 8 && ssCnt_q <= SS_CYC + 8;
	endproperty
	a_ss: assert property (p_ss) else $error("ramp length wrong");
	property p_duty; hsCnt_q < frequencySetInput + 12'h2; endproperty
	a_duty: assert property (p_duty) else $error("high side on too long");
	property p_trip; s_trip |=> !highSideOn; endproperty
	a_trip: assert property (p_trip) else $error("high side on in limit");
	property p_hic; ilimTrip && !outAboveGood && converterRunning |=> inHiccup; endproperty
	a_hic: assert property (p_hic) else $error("no hiccup on low limit");
	property p_hlen;
		$fell(inHiccup) && $past(highVoltageEnable) |->
			hicCnt_q >= HICCUP_CYC - 3 && hicCnt_q <= HICCUP_CYC + 3;
	endproperty
	a_hlen: assert property (p_hlen) else $error("hiccup length wrong");
	property p_good; $rose(converterRunning) |-> $past(outAboveGood); endproperty
	a_good: assert property (p_good) else $error("run with output low");
	// The latch takes one edge and the state a second one.
	sequence s_hot;
		thermalHot && highVoltageEnable ##1 highVoltageEnable;
	endsequence
	property p_hot; s_hot |=> thermalShutdown && !converterRunning; endproperty
	a_hot: assert property (p_hot) else $error("hot not shut down");
	property p_cool;
		$fell(thermalShutdown) && $past(highVoltageEnable) |->
			$past(thermalCool, 2) && outputReference < 16'h8;
	endproperty
	a_cool: assert property (p_cool) else $error("thermal exit wrong");
	property p_port; portOneBusOutput |-> !$past(portOneFault) && $past(converterRunning); endproperty
	a_port: assert property (p_port) else $error("port on in fault");
endmodule // bcc_sequencer_chk
bind bcc_sequencer bcc_sequencer_chk #(.SS_CYC(SS_CYC), .HICCUP_CYC(HICCUP_CYC))
	bcc_sequencer_chk_i (.*);
`default_nettype wire

// file: bcc_stage_model.sv
// Behavioural power stage and comparators facing the sequencer.
`default_nettype none
module bcc_stage_model (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        biasRegulatorOn,
	input  wire logic [15:0] outputReference,
	input  wire logic        weakOut,
	input  wire logic        shortOut,
	output var  logic        biasAboveLockout,
	output var  logic        outAboveGood,
	output var  logic        ilimTrip,
	output var  logic        ilimValley
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] biasCnt_q;
	// The bias rail needs a few cycles to cross lockout, so soft-start must wait.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			biasCnt_q <= 3'h0;
			biasAboveLockout <= 1'b0;
			outAboveGood <= 1'b0;
			ilimTrip <= 1'b0;
			ilimValley <= 1'b1;
		end else begin
			biasCnt_q <= biasRegulatorOn ? biasCnt_q + {2'h0, biasCnt_q != 3'h7} : 3'h0;
			biasAboveLockout <= biasRegulatorOn && biasCnt_q == 3'h7;
			outAboveGood <= !weakOut && !shortOut && outputReference > 16'h9c4;
			ilimTrip <= shortOut;
			ilimValley <= !shortOut;
		end
	end
endmodule // bcc_stage_model
`default_nettype wire

// file: tb_bcc_sequencer.sv
// Self-checking bench for the converter sequencer.
`default_nettype none
module tb_bcc_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SS = 5200;
	localparam int HIC = 100;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic highVoltageEnable = 1'b0, thermalHot = 1'b0, thermalCool = 1'b0;
	logic portOneFault = 1'b0, portTwoFault = 1'b0, weakOut = 1'b0, shortOut = 1'b0;
	logic [11:0] frequencySetInput = 12'h028;
	logic [11:0] dutyRequest = 12'hfff;
	logic biasAboveLockout, outAboveGood, ilimTrip, ilimValley;
	logic biasRegulatorOn, highSideOn, lowSideOn, converterRunning, inHiccup;
	logic thermalShutdown, portOneBusOutput, portTwoBusOutput;
	logic [15:0] outputReference;
	int err_total = 0;
	int n_compared = 0;
	bcc_sequencer #(.SPREAD(1), .SS_CYC(SS), .HICCUP_CYC(HIC)) bcc_sequencer_i (.*);
	bcc_stage_model bcc_stage_model_i (.*);
	// Free-running system clock.
	always #20 clk_sys = ~clk_sys;
	task automatic chk(input logic c, input string m);
		n_compared++;
		if (c !== 1'b1) begin
			err_total++;
			$display("unexpected %0t %s", $time, m);
		end
	endtask
	// Sampling 1 ns past the edge lets that edge's updates land first.
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wait_for(input int sel, input int lim);
		int n;
		n = 0;
		while (n < lim && (sel == 0 ? converterRunning : inHiccup) !== 1'b1) begin
			tick(1);
			n++;
		end
	endtask
	task automatic t_start;
		@(posedge clk_sys);
		highVoltageEnable <= 1'b1;
		tick(2);
		chk(biasRegulatorOn === 1'b1, "bias regulator off");
		wait_for(0, SS + 300);
		chk(outputReference === 16'h1450, "ref not at target");
		tick(3);
		chk(portOneBusOutput === 1'b1 && portTwoBusOutput === 1'b1, "port off");
		@(posedge clk_sys);
		portOneFault <= 1'b1;
		tick(3);
		chk(portOneBusOutput === 1'b0 && portTwoBusOutput === 1'b1, "ports coupled");
		@(posedge clk_sys);
		portOneFault <= 1'b0;
	endtask
	// At the duty cap the low side must be forced on in a short burst.
	task automatic t_drop;
		int run;
		int best;
		run = 0;
		best = 0;
		repeat (300) begin
			tick(1);
			run = (lowSideOn === 1'b1) ? run + 1 : 0;
			if (run > best) begin
				best = run;
			end
		end
		chk(best >= 4 && best <= 6, "no dropout refresh");
	endtask
	// A period set below the fastest legal one is clamped to twelve cycles.
	task automatic t_freq;
		int gap;
		@(posedge clk_sys);
		dutyRequest <= 12'h002;
		tick(60);
		frequencySetInput <= 12'h004;
		tick(30);
		while (highSideOn !== 1'b0) begin
			tick(1);
		end
		while (highSideOn !== 1'b1) begin
			tick(1);
		end
		gap = 0;
		do begin
			tick(1);
			gap++;
		end while (highSideOn !== 1'b0 && gap < 100);
		while (highSideOn !== 1'b1 && gap < 100) begin
			tick(1);
			gap++;
		end
		chk(gap == 12, "period not clamped");
		@(posedge clk_sys);
		frequencySetInput <= 12'h028;
		dutyRequest <= 12'hfff;
	endtask
	task automatic t_short;
		@(posedge clk_sys);
		shortOut <= 1'b1;
		wait_for(1, 50);
		chk(inHiccup === 1'b1 && outputReference === 16'h0, "no hiccup");
		@(posedge clk_sys);
		shortOut <= 1'b0;
		tick(HIC / 2);
		chk(inHiccup === 1'b1, "hiccup too short");
		wait_for(0, SS + HIC + 300);
		chk(converterRunning === 1'b1, "no restart after hiccup");
	endtask
	task automatic t_off;
		@(posedge clk_sys);
		highVoltageEnable <= 1'b0;
		tick(3);
		chk(!biasRegulatorOn && !highSideOn && !lowSideOn && !converterRunning, "on");
	endtask
	task automatic t_weak;
		@(posedge clk_sys);
		weakOut <= 1'b1;
		highVoltageEnable <= 1'b1;
		wait_for(1, SS + 300);
		chk(inHiccup === 1'b1 && converterRunning === 1'b0, "ran with low output");
		@(posedge clk_sys);
		weakOut <= 1'b0;
		wait_for(0, SS + HIC + 300);
		chk(converterRunning === 1'b1, "no run after retry");
	endtask
	task automatic t_therm;
		@(posedge clk_sys);
		thermalHot <= 1'b1;
		tick(2);
		chk(thermalShutdown === 1'b1 && converterRunning === 1'b0, "hot ignored");
		@(posedge clk_sys);
		thermalHot <= 1'b0;
		tick(20);
		chk(thermalShutdown === 1'b1, "restart before cooling");
		@(posedge clk_sys);
		thermalCool <= 1'b1;
		tick(3);
		chk(thermalShutdown === 1'b0 && outputReference < 16'h10, "no fresh ramp");
		@(posedge clk_sys);
		thermalCool <= 1'b0;
		wait_for(0, SS + 300);
		chk(converterRunning === 1'b1, "no run after cooling");
	endtask
	task automatic complete_run;
		$display("errors %0d compared %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Main sequence; reset is held for twelve cycles first.
	initial begin
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		tick(1);
		chk(!biasRegulatorOn && !converterRunning && !highSideOn, "live after reset");
		t_start;
		t_drop;
		t_freq;
		t_short;
		t_off;
		t_weak;
		t_therm;
		complete_run;
	end
	// The scenarios need under 30000 cycles, so twice that means a hang.
	initial begin
		repeat (60000) @(posedge clk_sys);
		err_total++;
		$display("unexpected %0t watchdog expired", $time);
		complete_run;
	end
endmodule // tb_bcc_sequencer
`default_nettype wire
